//--- rtl/dwscu_top.sv
// Purpose: serial command unit of a dual 256-position potentiometer
// Assumes: link clock comes from the master and runs only inside frames and read-outs
// Notes: frame word and length are held still while select is high
`timescale 1ns/1ns
`default_nettype none
module dwscu_top
    import dwscu_pkg::*;
#(
    parameter int unsigned BUSY_CYCLES = BUSY_CYC,
    parameter int unsigned PWRUP_CYCLES = PWRUP_CYC
) (
    input wire logic clk_sys_i, // system clock, 25 MHz
    input wire logic rst_n_i, // async reset, active low
    input wire logic sclk_i, // serial link clock from master
    input wire logic select_low_i, // frame select, active low
    input wire logic sdio_i, // data pin, input side
    output logic sdio_o, // data pin, output side
    output logic sdio_oe_o, // data pin drive enable
    output logic [POS_W-1:0] wiper_a_o, // wiper A tap position
    output logic [POS_W-1:0] wiper_b_o, // wiper B tap position
    output logic [POS_W-1:0] nv_a_o, // stored value A
    output logic [POS_W-1:0] nv_b_o, // stored value B
    output logic ready_o, // low during nv write
    output logic standby_o // low-power standby
);

    localparam int unsigned PUW = $clog2(PWRUP_CYCLES + 1);
    localparam logic [PUW-1:0] PU_LAST = PUW'(PWRUP_CYCLES - 1);

    // link domain state
    logic new_frame_q;
    logic [FRAME_W-1:0] word_q;
    logic [4:0] len_q;
    logic [3:0] rd_ph_q;
    logic [POS_W-1:0] rd_sh_q;
    logic rd_fin_q;
    logic sdio_q;
    logic oe_q;
    logic [CMD_W-1:0] link_cmd;
    logic link_read;

    // system domain state
    logic sel_hi_s;
    logic sel_hi_q;
    logic sel_rise;
    logic rd_fin_s;
    logic [CMD_W-1:0] cmd;
    logic [POS_W-1:0] pos;
    logic cmd_ok;
    logic [3:0] op;
    logic tgt_a;
    logic tgt_b;
    logic run;
    logic [POS_W-1:0] wiper_a_q;
    logic [POS_W-1:0] wiper_b_q;
    logic [POS_W-1:0] nv_a_q;
    logic [POS_W-1:0] nv_b_q;
    logic [POS_W-1:0] rd_val_q;
    logic rd_wait_q;
    logic pu_done_q;
    logic [PUW-1:0] pu_cnt_q;
    logic nv_start;
    logic nv_busy;
    logic ready_q;
    logic standby_q;

    // ------------------------------------------------------------------
    // link domain
    // ------------------------------------------------------------------

    // marks the next edge with select low as a frame's first bit
    always_ff @(posedge sclk_i or posedge select_low_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            new_frame_q <= 1'b1;
        else if (select_low_i)
            new_frame_q <= 1'b1;
        else
            new_frame_q <= 1'b0;
    end

    // shift in msb first, count bits while selected
    always_ff @(posedge sclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            word_q <= '0;
            len_q <= '0;
        end
        else if (!select_low_i)
        begin
            word_q <= {word_q[FRAME_W-2:0], sdio_i};
            if (new_frame_q)
                len_q <= 5'h01;
            else if (len_q != LEN_OVER)
                len_q <= len_q + 5'h01;
        end
    end

    // link side decode of the finished frame
    assign link_cmd = dwscu_frame_cmd(word_q, len_q);
    assign link_read = dwscu_is_read(link_cmd, len_q);

    // read-out phase counter, runs on edges after select rises
    always_ff @(posedge sclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rd_ph_q <= '0;
            rd_fin_q <= 1'b0;
        end
        else if (!select_low_i)
        begin
            rd_ph_q <= '0;
            rd_fin_q <= 1'b0;
        end
        else if (link_read && rd_ph_q != RD_STBY_PH)
        begin
            rd_ph_q <= rd_ph_q + 4'h1;
            if (rd_ph_q == RD_STBY_PH - 4'h1)
                rd_fin_q <= 1'b1;
        end
    end

    // shift the read value out msb first; rd_val_q is stable here
    always_ff @(posedge sclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rd_sh_q <= '0;
            sdio_q <= 1'b0;
        end
        else if (select_low_i && link_read)
        begin
            if (rd_ph_q == RD_FIRST_PH)
            begin
                sdio_q <= rd_val_q[POS_W-1];
                rd_sh_q <= {rd_val_q[POS_W-2:0], 1'b0};
            end
            else if (rd_ph_q > RD_FIRST_PH && rd_ph_q <= RD_LAST_PH)
            begin
                sdio_q <= rd_sh_q[POS_W-1];
                rd_sh_q <= {rd_sh_q[POS_W-2:0], 1'b0};
            end
        end
    end

    // pin turns output after select rises, input on select fall
    always_ff @(posedge sclk_i or negedge rst_n_i or negedge select_low_i)
    begin
        if (!rst_n_i)
            oe_q <= 1'b0;
        else if (!select_low_i)
            oe_q <= 1'b0;
        else if (link_read)
            oe_q <= 1'b1;
    end

    assign sdio_o = sdio_q;
    assign sdio_oe_o = oe_q;

    // ------------------------------------------------------------------
    // crossings into the system domain
    // ------------------------------------------------------------------

    // select level; frame word is frozen once this shows high
    dwscu_sync #(
        .W(1),
        .RST_VAL(1'b1)
    ) u_sel_sync (
        .clk_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .d_i(select_low_i),
        .q_o(sel_hi_s)
    );

    // end of read-out
    dwscu_sync #(
        .W(1),
        .RST_VAL(1'b0)
    ) u_fin_sync (
        .clk_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .d_i(rd_fin_q),
        .q_o(rd_fin_s)
    );

    // select rise detector
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            sel_hi_q <= 1'b1;
        else
            sel_hi_q <= sel_hi_s;
    end

    assign sel_rise = sel_hi_s && !sel_hi_q;

    // ------------------------------------------------------------------
    // command decode, system domain
    // ------------------------------------------------------------------

    // command byte first, data byte second; copy/read ignore data
    assign cmd = dwscu_frame_cmd(word_q, len_q);
    assign pos = word_q[POS_W-1:0];
    assign cmd_ok = dwscu_cmd_ok(cmd, len_q);
    assign op = cmd[OP_MSB:OP_LSB];
    assign tgt_a = cmd[SEL_A_BIT];
    assign tgt_b = cmd[SEL_B_BIT];
    assign run = sel_rise && cmd_ok && pu_done_q;

    // nv writes and wiper-to-nv copies start the busy cycle
    assign nv_start = run && !nv_busy &&
        (op == OP_WR_NV || op == OP_CP_W2NV);

    dwscu_busy_timer #(
        .CYC(BUSY_CYCLES)
    ) u_busy (
        .clk_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .start_i(nv_start),
        .busy_o(nv_busy)
    );

    // power-up reload delay, well inside the allowed time
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            pu_cnt_q <= '0;
            pu_done_q <= 1'b0;
        end
        else if (!pu_done_q)
        begin
            if (pu_cnt_q == PU_LAST || pu_cnt_q == '0)
                pu_done_q <= 1'b1;
            pu_cnt_q <= pu_cnt_q + 1'b1;
        end
    end

    // wiper registers: reload at power-up, writes and nv copies
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wiper_a_q <= WIPER_RESET;
            wiper_b_q <= WIPER_RESET;
        end
        else if (!pu_done_q)
        begin
            wiper_a_q <= nv_a_q;
            wiper_b_q <= nv_b_q;
        end
        else if (run && op == OP_WR_WIPER)
        begin
            if (tgt_a)
                wiper_a_q <= pos;
            if (tgt_b)
                wiper_b_q <= pos;
        end
        else if (run && op == OP_CP_NV2W)
        begin
            if (tgt_a)
                wiper_a_q <= nv_a_q;
            if (tgt_b)
                wiper_b_q <= nv_b_q;
        end
    end

    // nv registers: direct writes or wiper copies; wipers untouched
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            nv_a_q <= NV_RESET;
            nv_b_q <= NV_RESET;
        end
        else if (nv_start && op == OP_WR_NV)
        begin
            if (tgt_a)
                nv_a_q <= pos;
            if (tgt_b)
                nv_b_q <= pos;
        end
        else if (nv_start && op == OP_CP_W2NV)
        begin
            if (tgt_a)
                nv_a_q <= wiper_a_q;
            if (tgt_b)
                nv_b_q <= wiper_b_q;
        end
    end

    // value handed to the link for read-out, held until next read command
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rd_val_q <= '0;
        else if (run && op == OP_RD_WIPER)
            rd_val_q <= tgt_a ? wiper_a_q : wiper_b_q;
        else if (run && op == OP_RD_NV)
            rd_val_q <= tgt_a ? nv_a_q : nv_b_q;
    end

    // read-out pending: blocks standby until one edge after lsb
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rd_wait_q <= 1'b0;
        else if (run && (op == OP_RD_WIPER || op == OP_RD_NV))
            rd_wait_q <= 1'b1;
        else if (rd_fin_s || !sel_hi_s)
            rd_wait_q <= 1'b0;
    end

    // registered status outputs
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ready_q <= 1'b1;
            standby_q <= 1'b0;
        end
        else
        begin
            ready_q <= !nv_busy;
            standby_q <= sel_hi_s && !rd_wait_q && !rd_wait_start();
        end
    end

    // read accepted this cycle, standby must not flash high
    function automatic logic rd_wait_start();
        return run && (op == OP_RD_WIPER || op == OP_RD_NV);
    endfunction : rd_wait_start

    // wiper code maps straight to the tap, 00 low end, ff high end
    assign wiper_a_o = wiper_a_q;
    assign wiper_b_o = wiper_b_q;
    assign nv_a_o = nv_a_q;
    assign nv_b_o = nv_b_q;
    assign ready_o = ready_q;
    assign standby_o = standby_q;

endmodule : dwscu_top
`default_nettype wire

//--- rtl/dwscu_pkg.sv
// Purpose: shared constants, codes and decode helpers of the wiper unit
// Assumes: system clock at 25 MHz, serial frames of 8 or 16 bits
// Notes: read codes are local picks, the other codes are fixed
package dwscu_pkg;

    // clock and timing
    localparam int unsigned CLK_SYS_HZ = 25_000_000;
    localparam int unsigned BUSY_MS = 20; // nv write busy time, at most
    localparam int unsigned BUSY_CYC = BUSY_MS * (CLK_SYS_HZ / 1000);
    localparam int unsigned PWRUP_NS = 5000; // reload completes within
    localparam int unsigned PWRUP_CYC = (PWRUP_NS * (CLK_SYS_HZ / 1000000))
        / 1000;

    // widths and frame lengths
    localparam int unsigned POS_W = 8;
    localparam int unsigned CMD_W = 8;
    localparam int unsigned FRAME_W = 16;
    localparam logic [4:0] LEN_SHORT = 5'h08;
    localparam logic [4:0] LEN_LONG = 5'h10;
    localparam logic [4:0] LEN_OVER = 5'h11; // saturates here

    // command byte fields
    localparam int unsigned OP_MSB = 7;
    localparam int unsigned OP_LSB = 4;
    localparam int unsigned SEL_A_BIT = 0;
    localparam int unsigned SEL_B_BIT = 1;
    localparam logic [3:0] OP_WR_WIPER = 4'h0;
    localparam logic [3:0] OP_WR_NV = 4'h1;
    localparam logic [3:0] OP_CP_W2NV = 4'h2;
    localparam logic [3:0] OP_CP_NV2W = 4'h3;
    localparam logic [3:0] OP_RD_WIPER = 4'h4;
    localparam logic [3:0] OP_RD_NV = 4'h5;

    // reset values
    localparam logic [7:0] NV_RESET = 8'h80; // mid-scale factory value
    localparam logic [7:0] WIPER_RESET = 8'h80;

    // read-out phases, counted in link edges after select rises
    localparam logic [3:0] RD_FIRST_PH = 4'h1; // edge 2 drives msb
    localparam logic [3:0] RD_LAST_PH = 4'h8; // edge 9 drives lsb
    localparam logic [3:0] RD_STBY_PH = 4'ha; // edge 10: standby

    // command byte of a frame: first byte shifted in
    function automatic logic [7:0] dwscu_frame_cmd(
        input logic [15:0] word,
        input logic [4:0] len
    );
        logic [7:0] cmd;
        cmd = (len == LEN_LONG) ? word[15:8] : word[7:0];
        return cmd;
    endfunction : dwscu_frame_cmd

    // legal command for the given frame length
    function automatic logic dwscu_cmd_ok(
        input logic [7:0] cmd,
        input logic [4:0] len
    );
        logic ok;
        logic [3:0] op;
        op = cmd[OP_MSB:OP_LSB];
        ok = (cmd[3:2] == 2'h0) && (cmd[1:0] != 2'h0);
        if (len != LEN_SHORT && len != LEN_LONG)
            ok = 1'b0;
        else if (op == OP_WR_WIPER || op == OP_WR_NV)
            ok = ok && (len == LEN_LONG);
        else if (op == OP_RD_WIPER || op == OP_RD_NV)
            ok = ok && (cmd[1:0] != 2'h3);
        else if (op != OP_CP_W2NV && op != OP_CP_NV2W)
            ok = 1'b0;
        return ok;
    endfunction : dwscu_cmd_ok

    // legal read command
    function automatic logic dwscu_is_read(
        input logic [7:0] cmd,
        input logic [4:0] len
    );
        logic rd;
        rd = dwscu_cmd_ok(cmd, len) &&
            (cmd[OP_MSB:OP_LSB] == OP_RD_WIPER ||
             cmd[OP_MSB:OP_LSB] == OP_RD_NV);
        return rd;
    endfunction : dwscu_is_read

endpackage : dwscu_pkg

//--- rtl/dwscu_sync.sv
// Purpose: two-flop level synchroniser
// Assumes: input is a slow level from another domain
// Notes: first stage feeds only the second stage
`timescale 1ns/1ns
`default_nettype none
module dwscu_sync #(
    parameter int unsigned W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk_i, // destination clock
    input wire logic rst_n_i, // async reset, active low
    input wire logic [W-1:0] d_i, // foreign level
    output logic [W-1:0] q_o // synchronised level
);

    logic [W-1:0] meta_q;

    // two stages in series
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            meta_q <= RST_VAL;
            q_o <= RST_VAL;
        end
        else
        begin
            meta_q <= d_i;
            q_o <= meta_q;
        end
    end

endmodule : dwscu_sync
`default_nettype wire

//--- rtl/dwscu_busy_timer.sv
// Purpose: non-volatile write busy timer
// Assumes: start pulse is one system cycle
// Notes: a start while busy is not accepted
`timescale 1ns/1ns
`default_nettype none
module dwscu_busy_timer #(
    parameter int unsigned CYC = 500000
) (
    input wire logic clk_i, // system clock
    input wire logic rst_n_i, // async reset, active low
    input wire logic start_i, // begin a write cycle
    output logic busy_o // write cycle in progress
);

    localparam int unsigned CW = $clog2(CYC + 1);
    localparam logic [CW-1:0] LAST = CW'(CYC - 1);

    logic [CW-1:0] cnt_q;

    // count busy cycles down to the end
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cnt_q <= '0;
            busy_o <= 1'b0;
        end
        else if (start_i && !busy_o)
        begin
            cnt_q <= LAST;
            busy_o <= 1'b1;
        end
        else if (busy_o)
        begin
            if (cnt_q == '0)
                busy_o <= 1'b0;
            else
                cnt_q <= cnt_q - 1'b1;
        end
    end

endmodule : dwscu_busy_timer
`default_nettype wire

//--- test/dwscu_checker.sv
// Purpose: port assertions of the wiper command unit
// Assumes: all checks sampled on the system clock
// Notes: bound into dwscu_top after the module
`timescale 1ns/1ns
`default_nettype none
module dwscu_checker
    import dwscu_pkg::*;
#(
    parameter int unsigned BUSY_CYCLES = 20
) (
    input wire logic clk_sys_i, // system clock
    input wire logic rst_n_i, // async reset, active low
    input wire logic sclk_i, // link clock
    input wire logic select_low_i, // frame select
    input wire logic sdio_i, // pin, input side
    input wire logic sdio_o, // pin, output side
    input wire logic sdio_oe_o, // pin drive enable
    input wire logic [POS_W-1:0] wiper_a_o, // wiper A
    input wire logic [POS_W-1:0] wiper_b_o, // wiper B
    input wire logic [POS_W-1:0] nv_a_o, // stored A
    input wire logic [POS_W-1:0] nv_b_o, // stored B
    input wire logic ready_o, // low while busy
    input wire logic standby_o // standby flag
);
    int unsigned busy_cnt_q;
    // length of the current low phase of ready
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            busy_cnt_q <= 0;
        else if (!ready_o)
            busy_cnt_q <= busy_cnt_q + 1;
        else
            busy_cnt_q <= 0;
    end
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    // busy window bounds and contents
    chk_busy_max: assert property (busy_cnt_q <= BUSY_CYCLES)
        else $error("ready low too long");
    chk_busy_len: assert property ($rose(ready_o) |->
        busy_cnt_q == BUSY_CYCLES) else $error("busy length wrong");
    chk_busy_nv_hold: assert property ((!ready_o && !$past(ready_o)) |->
        ($stable(nv_a_o) && $stable(nv_b_o))) else $error("nv moved");
    chk_nv_ready_fall: assert property (($changed(nv_a_o) ||
        $changed(nv_b_o)) |-> ##[0:2] !ready_o) else $error("no busy");
    // command effects, pin direction and standby
    chk_nv_wiper_apart: assert property (($changed(nv_a_o) ||
        $changed(nv_b_o)) |-> ($stable(wiper_a_o) && $stable(wiper_b_o)))
        else $error("wiper moved on nv write");
    chk_exec_sel_high: assert property (($changed(wiper_a_o) ||
        $changed(wiper_b_o)) |-> (select_low_i && $past(select_low_i, 2)))
        else $error("wiper moved in frame");
    chk_oe_sel_low: assert property ((!select_low_i &&
        !$past(select_low_i)) |-> !sdio_oe_o) else $error("pin driven");
    chk_stby_sel_low: assert property (!select_low_i [*4] |->
        !standby_o) else $error("standby in frame");
    cover property ($fell(ready_o));
    cover property ($rose(sdio_oe_o));
    cover property ($rose(standby_o));
endmodule : dwscu_checker
bind dwscu_top dwscu_checker #(.BUSY_CYCLES(BUSY_CYCLES)) dwscu_checker_inst (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .sclk_i(sclk_i),
    .select_low_i(select_low_i), .sdio_i(sdio_i), .sdio_o(sdio_o),
    .sdio_oe_o(sdio_oe_o), .wiper_a_o(wiper_a_o), .wiper_b_o(wiper_b_o),
    .nv_a_o(nv_a_o), .nv_b_o(nv_b_o), .ready_o(ready_o),
    .standby_o(standby_o));
`default_nettype wire

//--- test/dwscu_spi_master.sv
// Purpose: serial master model on the far side of the link
// Assumes: link clock 160 ns, runs only inside frames and read-outs
// Notes: drives the pin except while the unit drives it
`timescale 1ns/1ns
`default_nettype none
module dwscu_spi_master (
    output logic sclk_o, // link clock, idle low
    output logic select_low_o, // frame select
    output logic sdio_o, // master drive of the pin
    input wire logic sdio_i // resolved pin level
);
    // idle levels
    initial
    begin
        sclk_o = 1'b0;
        select_low_o = 1'b1;
        sdio_o = 1'b0;
    end
    // frame of len bits, msb first, select low throughout
    task automatic send(input logic [15:0] w, input int len);
        select_low_o <= 1'b0;
        #80;
        for (int i = len - 1; i >= 0; i--)
        begin
            sdio_o <= (i < 16) ? w[i] : 1'b0;
            #80 sclk_o <= 1'b1;
            #80 sclk_o <= 1'b0;
        end
        #80 select_low_o <= 1'b1;
        sdio_o <= ~sdio_o; // released line shows no stale bit
        #400;
    endtask : send
    // read-out: data from the second edge, taken at each fall
    task automatic read(output logic [7:0] q);
        q = 8'h00;
        for (int e = 1; e <= 11; e++)
        begin
            #80 sclk_o <= 1'b1;
            #80 sclk_o <= 1'b0;
            if (e >= 2 && e <= 9)
                q = {q[6:0], sdio_i};
        end
    endtask : read
endmodule : dwscu_spi_master
`default_nettype wire

//--- test/tb_dwscu_top.sv
// Purpose: self-checking bench of the wiper command unit
// Assumes: busy time shortened to 200 system cycles
// Notes: reset first, then table rows, busy and read-out cases, then mid-run reset
`timescale 1ns/1ns
`default_nettype none
module tb_dwscu_top;
    localparam int unsigned BUSY = 200;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic sclk, select_low, m_sdio, sdio_pad, sdio_o, sdio_oe_o;
    logic [7:0] wa, wb, na, nb;
    logic ready, standby;
    int miscompares = 0;
    int checks = 0;
    logic [15:0] rw_word [0:19] = '{16'h015a, 16'h02ff, 16'h0300,
        16'h11c3, 16'h1224, 16'h0031, 16'h0032, 16'h0366, 16'h0021,
        16'h2200, 16'h0177, 16'h0023, 16'h13a5, 16'h3300, 16'h0001,
        16'h0071, 16'h0744, 16'h0155, 16'h0030, 16'h0255};
    int rw_len [0:19] = '{16, 16, 16, 16, 16, 8, 8, 16, 8, 16, 16, 8,
        16, 16, 8, 8, 16, 12, 8, 17};
    logic [31:0] rw_exp [0:19] = '{32'h5a808080, 32'h5aff8080,
        32'h00008080, 32'h0000c380, 32'h0000c324, 32'hc300c324,
        32'hc324c324, 32'h6666c324, 32'h66666624, 32'h66666666,
        32'h77666666, 32'h77667766, 32'h7766a5a5, 32'ha5a5a5a5,
        32'ha5a5a5a5, 32'ha5a5a5a5, 32'ha5a5a5a5, 32'ha5a5a5a5,
        32'ha5a5a5a5, 32'ha5a5a5a5};
    // system clock and resolved pin
    always #20 clk_sys_i = ~clk_sys_i;
    assign sdio_pad = sdio_oe_o ? sdio_o : m_sdio;
    dwscu_spi_master dwscu_spi_master_inst (.sclk_o(sclk),
        .select_low_o(select_low), .sdio_o(m_sdio), .sdio_i(sdio_pad));
    dwscu_top #(.BUSY_CYCLES(BUSY)) dwscu_top_inst (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .sclk_i(sclk),
        .select_low_i(select_low), .sdio_i(sdio_pad), .sdio_o(sdio_o),
        .sdio_oe_o(sdio_oe_o), .wiper_a_o(wa), .wiper_b_o(wb),
        .nv_a_o(na), .nv_b_o(nb), .ready_o(ready), .standby_o(standby));
    // compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
        input string what);
        checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("MISMATCH %0t %s: %h not %h", $time, what, seen, exp);
        end
    endtask : check
    task final_report;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : final_report
    // let the command land, then wait out any busy phase
    task automatic wait_ready;
        int n;
        n = 0;
        repeat (10) @(posedge clk_sys_i);
        #1;
        while (ready !== 1'b1 && n < 600)
        begin
            @(posedge clk_sys_i);
            #1;
            n++;
        end
        if (n >= 600)
        begin
            miscompares++;
            final_report();
        end
    endtask : wait_ready
    task automatic do_read(input logic [15:0] w, input int len,
        input logic [7:0] exp);
        logic [7:0] q;
        dwscu_spi_master_inst.send(w, len);
        dwscu_spi_master_inst.read(q);
        check(q, exp, "read data");
        check(sdio_oe_o, 1'b1, "pin drive");
        repeat (10) @(posedge clk_sys_i);
        #1;
        check(standby, 1'b1, "read standby");
        $display("read %h done", w);
    endtask : do_read
    // main sequence
    initial
    begin
        repeat (3) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        @(posedge clk_sys_i);
        #1;
        check({wa, wb, na, nb}, 32'h80808080, "reset");
        check(ready, 1'b1, "reset ready");
        $display("reset test done");
        for (int r = 0; r < 20; r++)
        begin
            dwscu_spi_master_inst.send(rw_word[r], rw_len[r]);
            wait_ready();
            check({wa, wb, na, nb}, rw_exp[r], "row");
            check(standby, 1'b1, "row standby");
            $display("row %0d done", r);
        end
        dwscu_spi_master_inst.send(16'h1111, 16);
        check(ready, 1'b0, "busy ready");
        dwscu_spi_master_inst.send(16'h0021, 8);
        wait_ready();
        check({wa, na}, 16'ha511, "copy while busy");
        $display("busy test done");
        dwscu_spi_master_inst.send(16'h013c, 16);
        wait_ready();
        do_read(16'h0041, 8, 8'h3c);
        do_read(16'h0042, 8, 8'ha5);
        do_read(16'h5100, 16, 8'h11);
        do_read(16'h0052, 8, 8'ha5);
        // mid-run reset: stored values back to mid-scale, pin released
        @(posedge clk_sys_i);
        rst_n_i <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
        #1;
        check({wa, wb, na, nb}, 32'h80808080, "reset again");
        check({ready, standby, sdio_oe_o}, 3'b100, "reset pins");
        @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        #1;
        check({wa, wb}, 16'h8080, "reload");
        check(standby, 1'b1, "standby after reset");
        $display("mid-run reset test done");
        final_report();
    end
endmodule : tb_dwscu_top
`default_nettype wire
